// File: hdl/fer_consts.svh
// constants for the fp exception report block: offsets, fields, resets
`ifndef FER_CONSTS_SVH
`define FER_CONSTS_SVH

`define FER_A_CTRL 4'h0
`define FER_A_STAT 4'h1
`define FER_A_TAG 4'h2
`define FER_A_SYS 4'h3
`define FER_A_FIP 4'h4

`define FER_ST_IE 0
`define FER_ST_SF 6
`define FER_ST_ES 7
`define FER_ST_C1 9
`define FER_ST_TOP_LO 11
`define FER_ST_WMASK 16'h47FF

`define FER_SYS_NE 0
`define FER_MASK_RST 6'h3F
`define FER_STAT_RST 16'h0000
`define FER_TOP_RST 3'h0
`define FER_TAG_RST 1'b1

`define FER_IND_REAL 80'hFFFF_C000_0000_0000_0000
`define FER_IND_INT 80'h0000_8000_0000_0000_0000
`define FER_IND_BCD 80'hFFFF_C000_0000_0000_0000

`endif

// File: hdl/fer_pkg.sv
// types shared by the fp exception report block
package fer_pkg;
   typedef enum logic [2:0] {
      FER_OP_OTHER = 3'h0,
      FER_OP_NOWAIT = 3'h1,
      FER_OP_FPWAIT = 3'h2,
      FER_OP_WAIT = 3'h3,
      FER_OP_PACKED = 3'h4
   } fer_op_e;
   typedef enum logic [1:0] {
      FER_IND_K_REAL = 2'h0,
      FER_IND_K_INT = 2'h1,
      FER_IND_K_BCD = 2'h2
   } fer_ind_e;
   typedef enum logic [1:0] {
      FER_PIN_IDLE = 2'b00,
      FER_PIN_DEFER = 2'b01,
      FER_PIN_ASSERT = 2'b11
   } fer_pin_e;
endpackage

// File: hdl/fer_stk_if.sv
// signals between the report logic and the register stack tracker
`timescale 1ns/1ps
`default_nettype none
interface fer_stk_if;
   logic push;
   logic pop;
   logic rd;
   logic [2:0] idx;
   logic commit;
   logic ovf;
   logic unf;
   logic [2:0] top;
   logic [7:0] empty;
   logic tag_wr;
   logic [7:0] tag_wdata;
   modport main (output push, pop, rd, idx, commit, tag_wr, tag_wdata,
      input ovf, unf, top, empty);
   modport stk (input push, pop, rd, idx, commit, tag_wr, tag_wdata,
      output ovf, unf, top, empty);
endinterface
`default_nettype wire

// File: hdl/fer_stack.sv
// eight-entry register stack tracker: top pointer, empty tags, faults
`timescale 1ns/1ps
`default_nettype none
`include "fer_consts.svh"
module fer_stack (
   input wire logic clk,
   input wire logic rst_n,
   fer_stk_if.stk sp
);
   logic [2:0] top_r;
   logic [7:0] empty_r;
   logic [2:0] dn;
   logic [2:0] rd_slot;

   // 3-bit arithmetic gives the wraparound for free
   assign dn = top_r - 3'h1;
   assign rd_slot = top_r + sp.idx;
   assign sp.ovf = sp.push && !empty_r[dn];
   assign sp.unf = (sp.rd && empty_r[rd_slot]) || (sp.pop && empty_r[top_r]);
   assign sp.top = top_r;
   assign sp.empty = empty_r;

   // pointer moves only on commit, so an unmasked fault leaves it alone
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         top_r <= `FER_TOP_RST;
      end else if (sp.commit && sp.push) begin
         top_r <= dn;
      end else if (sp.commit && sp.pop) begin
         top_r <= top_r + 3'h1;
      end
   end

   for (genvar i = 0; i < 8; i++) begin : g_tag
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            empty_r[i] <= `FER_TAG_RST;
         end else if (sp.tag_wr) begin
            empty_r[i] <= sp.tag_wdata[i];
         end else if (sp.commit && sp.push && (dn == 3'(i))) begin
            empty_r[i] <= 1'b0;
         end else if (sp.commit && sp.pop && (top_r == 3'(i))) begin
            empty_r[i] <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// File: hdl/fer_top.sv
// fp exception report: sticky flags, stack faults, error pin and freeze
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "fer_consts.svh"
module fer_top (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic [3:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   input wire logic OP_VALID,
   input wire fer_pkg::fer_op_e OP_CLASS,
   input wire logic OP_PUSH,
   input wire logic OP_POP,
   input wire logic OP_READ,
   input wire logic [2:0] OP_IDX,
   input wire logic [5:0] OP_EXC,
   input wire logic OP_DEFER,
   input wire fer_pkg::fer_ind_e OP_IND_KIND,
   input wire logic [31:0] OP_IP,
   output logic STALL,
   output logic COMMIT,
   output logic IND_VALID,
   output logic [79:0] IND_DATA,
   output logic FP_ERROR_VECTOR,
   output logic FP_ERROR_OUT_N,
   input wire logic IGNORE_NUMERIC_ERROR_IN_N,
   input wire logic MASKABLE_IRQ_IN
);
   import fer_pkg::*;

   fer_stk_if stk ();
   fer_stack u_stack (
      .clk(CLK),
      .rst_n(RESETN),
      .sp(stk.stk)
   );

   logic [1:0] ign_sync_r;
   logic [1:0] irq_sync_r;
   logic ign_s;
   logic irq_s;
   logic [5:0] mask_r;
   logic [15:0] stat_r;
   logic [15:0] stat_nxt;
   logic ne_r;
   logic [31:0] fip_r;
   logic [31:0] rd_mux;
   logic [31:0] rdata_r;
   fer_pin_e pin_st_r;
   fer_pin_e pin_st_nxt;
   logic pin_n_r;
   logic vec_r;
   logic vec_sent_r;
   logic ind_valid_r;
   logic [79:0] ind_data_r;
   logic waiting;
   logic pending;
   logic compat_ign;
   logic op_go;
   logic sfault;
   logic any_unm;
   logic [5:0] exc;
   logic [5:0] unm;

   // pins from outside: two flops before use
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ign_sync_r <= 2'b11;
         irq_sync_r <= 2'b00;
      end else begin
         ign_sync_r <= {ign_sync_r[0], IGNORE_NUMERIC_ERROR_IN_N};
         irq_sync_r <= {irq_sync_r[0], MASKABLE_IRQ_IN};
      end
   end
   assign ign_s = !ign_sync_r[1];
   assign irq_s = irq_sync_r[1];

   assign waiting = (OP_CLASS == FER_OP_FPWAIT) || (OP_CLASS == FER_OP_WAIT)
      || (OP_CLASS == FER_OP_PACKED);
   assign pending = stat_r[`FER_ST_ES];
   assign compat_ign = !ne_r && ign_s;
   // non-waiting ops never freeze
   assign STALL = OP_VALID && waiting && pending && !compat_ign;
   assign op_go = OP_VALID && !STALL;

   assign stk.push = OP_PUSH;
   assign stk.pop = OP_POP;
   assign stk.rd = OP_READ;
   assign stk.idx = OP_IDX;
   assign stk.tag_wr = WR && (ADDR == `FER_A_TAG);
   assign stk.tag_wdata = WDATA[7:0];

   assign sfault = stk.ovf || stk.unf;
   assign exc = {OP_EXC[5:1], OP_EXC[0] | sfault};
   assign unm = exc & ~mask_r;
   assign any_unm = op_go && (|unm);
   assign COMMIT = op_go && !any_unm;
   assign stk.commit = COMMIT;

   // set wins over a software write in the same cycle
   always_comb begin
      stat_nxt = stat_r;
      if (WR && (ADDR == `FER_A_STAT)) begin
         stat_nxt = WDATA[15:0] & `FER_ST_WMASK;
      end
      if (op_go) begin
         stat_nxt[5:0] = stat_nxt[5:0] | exc;
         if (any_unm) begin
            stat_nxt[`FER_ST_ES] = 1'b1;
         end
         if (sfault) begin
            stat_nxt[`FER_ST_SF] = 1'b1;
            stat_nxt[`FER_ST_C1] = stk.ovf;
         end
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         stat_r <= `FER_STAT_RST;
      end else begin
         stat_r <= stat_nxt;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         mask_r <= `FER_MASK_RST;
         ne_r <= 1'b0;
      end else begin
         if (WR && (ADDR == `FER_A_CTRL)) begin
            mask_r <= WDATA[5:0];
         end
         if (WR && (ADDR == `FER_A_SYS)) begin
            ne_r <= WDATA[`FER_SYS_NE];
         end
      end
   end

   // only the first fault of an episode is kept; later ones leave it unchanged
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         fip_r <= 32'h0000_0000;
      end else if (any_unm && !pending) begin
         fip_r <= OP_IP;
      end
   end

   // external error pin, compatibility mode only
   always_comb begin
      pin_st_nxt = pin_st_r;
      unique case (pin_st_r)
         FER_PIN_IDLE: begin
            if (any_unm || pending) begin
               if (any_unm && !OP_DEFER && !ign_s) begin
                  pin_st_nxt = FER_PIN_ASSERT;
               end else begin
                  pin_st_nxt = FER_PIN_DEFER;
               end
            end
         end
         FER_PIN_DEFER: begin
            if (!ign_s && OP_VALID && waiting) begin
               pin_st_nxt = FER_PIN_ASSERT;
            end
         end
         FER_PIN_ASSERT: begin
            pin_st_nxt = FER_PIN_ASSERT;
         end
         default: begin
            pin_st_nxt = FER_PIN_IDLE;
         end
      endcase
      if (ne_r || (!pending && !any_unm)) begin
         pin_st_nxt = FER_PIN_IDLE;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         pin_st_r <= FER_PIN_IDLE;
         pin_n_r <= 1'b1;
      end else begin
         pin_st_r <= pin_st_nxt;
         pin_n_r <= (pin_st_nxt != FER_PIN_ASSERT);
      end
   end
   assign FP_ERROR_OUT_N = pin_n_r;

   // native mode: one vector per pending episode at the frozen op
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         vec_r <= 1'b0;
         vec_sent_r <= 1'b0;
      end else begin
         vec_r <= ne_r && STALL && !vec_sent_r;
         vec_sent_r <= (pending || any_unm) && (vec_sent_r || (ne_r && STALL));
      end
   end
   assign FP_ERROR_VECTOR = vec_r;

   // default result for a masked stack fault
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ind_valid_r <= 1'b0;
         ind_data_r <= 80'h0000_0000_0000_0000_0000;
      end else begin
         ind_valid_r <= op_go && sfault && mask_r[`FER_ST_IE];
         if (op_go && sfault) begin
            unique case (OP_IND_KIND)
               FER_IND_K_INT: ind_data_r <= `FER_IND_INT;
               FER_IND_K_BCD: ind_data_r <= `FER_IND_BCD;
               default: ind_data_r <= `FER_IND_REAL;
            endcase
         end
      end
   end
   assign IND_VALID = ind_valid_r;
   assign IND_DATA = ind_data_r;

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (ADDR)
         `FER_A_CTRL: rd_mux = {26'h000_0000, mask_r};
         `FER_A_STAT: rd_mux = {16'h0000, stat_r[15:14], stk.top, stat_r[10:0]};
         `FER_A_TAG: rd_mux = {24'h00_0000, stk.empty};
         `FER_A_SYS: rd_mux = {29'h0000_0000, irq_s, ign_s, ne_r};
         `FER_A_FIP: rd_mux = fip_r;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rdata_r <= 32'h0000_0000;
      end else begin
         rdata_r <= RD ? rd_mux : 32'h0000_0000;
      end
   end
   assign RDATA = rdata_r;

   flag_set_a: assert property (@(posedge CLK) disable iff (!RESETN)
      any_unm |=> stat_r[`FER_ST_ES] && ((stat_r[5:0] & $past(unm)) == $past(unm)))
      else $error("unmasked exception did not set flags");
   stack_bits_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (op_go && sfault) |=> stat_r[`FER_ST_IE] && stat_r[`FER_ST_SF])
      else $error("stack fault did not set bits 0 and 6");
   cc_one_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (op_go && sfault) |=> stat_r[`FER_ST_C1] == $past(stk.ovf))
      else $error("condition bit wrong after stack fault");
   sf_keep_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (stat_r[`FER_ST_SF] && !(WR && (ADDR == `FER_A_STAT))) |=> stat_r[`FER_ST_SF])
      else $error("stack fault flag dropped by hardware");
   top_hold_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (any_unm && !stk.tag_wr) |=> $stable(stk.top))
      else $error("top moved on unmasked fault");
   pin_now_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (pin_st_r == FER_PIN_IDLE && any_unm && !ne_r && !ign_s && !OP_DEFER)
      |=> !FP_ERROR_OUT_N)
      else $error("error pin not raised at once");
   pin_ign_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (ign_s && FP_ERROR_OUT_N) |=> FP_ERROR_OUT_N)
      else $error("error pin raised while ignored");
   pin_rel_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (!pending && !any_unm) |=> FP_ERROR_OUT_N)
      else $error("error pin held after flags cleared");
   vec_once_a: assert property (@(posedge CLK) disable iff (!RESETN)
      FP_ERROR_VECTOR |-> $past(ne_r) && $past(STALL) ##1 !FP_ERROR_VECTOR)
      else $error("vector not a single pulse at a frozen op");
   nowait_go_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (OP_VALID && OP_CLASS == FER_OP_NOWAIT) |-> !STALL)
      else $error("non-waiting op was frozen");
   masked_ind_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (op_go && sfault && mask_r[0]) |=> IND_VALID ##1 !IND_VALID || $past(op_go))
      else $error("no indefinite value for masked stack fault");
endmodule
`default_nettype wire

// File: verif/fer_pic_model.sv
// far-side glue and cascaded interrupt controller model
`timescale 1ns/1ps
`default_nettype none
module fer_pic_model #(
   parameter logic [7:0] VEC = 8'h75
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic err_n,
   output logic irq,
   output logic [7:0] vec
);
   // level routed: request stays up while the pin is low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= ~err_n;
      end
   end
   assign vec = irq ? VEC : 8'h00;
endmodule
`default_nettype wire

// File: verif/fer_top_tb_top.sv
// self-checking bench for the fp exception report block
`timescale 1ns/1ps
`default_nettype none
`include "fer_consts.svh"
module fer_top_tb_top;
   import fer_pkg::*;
   logic clk, rst_n, wr, rd, op_v, op_push, op_pop, op_rd, op_dfr, ign_n, irq;
   logic stall, commit, ind_v, err_n, vec16;
   logic [3:0] addr;
   logic [31:0] wdata, rdata, op_ip, seed, v, ip, t0;
   logic [2:0] op_idx;
   logic [5:0] op_exc, acc;
   logic [79:0] ind_d;
   logic [7:0] pvec;
   fer_op_e op_cls;
   fer_ind_e op_kind;
   int err_total, checks_done, n;
   logic [3:0] ra [5] = '{`FER_A_CTRL, `FER_A_TAG, `FER_A_SYS, `FER_A_FIP, 4'h7};
   logic [31:0] re [5] = '{32'h0000_003F, 32'h0000_00FF, 32'h0, 32'h0, 32'h0};
   logic [79:0] indv [3] = '{`FER_IND_REAL, `FER_IND_INT, `FER_IND_BCD};
   fer_top u_dut (.CLK(clk), .RESETN(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .OP_VALID(op_v), .OP_CLASS(op_cls), .OP_PUSH(op_push), .OP_POP(op_pop),
      .OP_READ(op_rd), .OP_IDX(op_idx), .OP_EXC(op_exc), .OP_DEFER(op_dfr),
      .OP_IND_KIND(op_kind), .OP_IP(op_ip), .STALL(stall), .COMMIT(commit),
      .IND_VALID(ind_v), .IND_DATA(ind_d), .FP_ERROR_VECTOR(vec16), .FP_ERROR_OUT_N(err_n),
      .IGNORE_NUMERIC_ERROR_IN_N(ign_n), .MASKABLE_IRQ_IN(irq));
   fer_pic_model u_pic (.clk(clk), .rst_n(rst_n), .err_n(err_n), .irq(irq), .vec(pvec));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [15:0] st(input logic ie, sf, es, c1);
      return {6'h0, c1, 1'b0, es, sf, 5'h0, ie};
   endfunction
   task automatic chk(input string nm, input logic [79:0] e, input logic [79:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk1(input string nm, input logic e, input logic g);
      chk(nm, {79'h0, e}, {79'h0, g});
   endtask
   task automatic conclude();
      if (err_total == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      v = rdata;
   endtask
   // top bits masked: they move with pushes and are checked apart
   task automatic stat(input logic [15:0] e);
      rreg(`FER_A_STAT);
      chk("status", 80'(e), 80'(v[15:0] & `FER_ST_WMASK));
   endtask
   task automatic op(input fer_op_e c, input logic [2:0] k, input logic [5:0] x,
      input logic d, input fer_ind_e ik, input logic [31:0] p);
      @(posedge clk);
      op_v <= 1'b1;
      op_cls <= c;
      {op_push, op_pop, op_rd} <= k;
      op_exc <= x;
      op_dfr <= d;
      op_kind <= ik;
      op_ip <= p;
      @(negedge clk);
   endtask
   task automatic drop();
      @(posedge clk);
      op_v <= 1'b0;
      {op_push, op_pop, op_rd} <= 3'h0;
      op_exc <= 6'h00;
      @(negedge clk);
   endtask
   task automatic go(input fer_op_e c, input logic [2:0] k, input logic [5:0] x);
      op(c, k, x, 1'b0, FER_IND_K_REAL, 32'h0);
      drop();
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      conclude();
   end
   initial begin
      seed = 32'h0000_A00E;
      err_total = 0;
      checks_done = 0;
      {rst_n, wr, rd, op_v, op_push, op_pop, op_rd, op_dfr} = '0;
      {addr, wdata, op_idx, op_exc, op_ip} = '0;
      op_idx = 3'h3;
      op_cls = FER_OP_OTHER;
      op_kind = FER_IND_K_REAL;
      ign_n = 1'b1;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      wreg(4'h7, '1);
      foreach (ra[i]) begin
         rreg(ra[i]);
         chk("reset read", 80'(re[i]), 80'(v));
      end
      wreg(`FER_A_STAT, '1);
      stat(`FER_ST_WMASK);
      wreg(`FER_A_STAT, 32'h0);
      acc = 6'h00;
      repeat (20) begin
         ip = xs();
         op(FER_OP_OTHER, 3'h0, ip[5:0], 1'b0, FER_IND_K_REAL, ip);
         acc |= ip[5:0];
         chk1("commit", 1'b1, commit);
      end
      drop();
      stat({10'h0, acc});
      wreg(`FER_A_STAT, 32'h0);
      repeat (8) op(FER_OP_OTHER, 3'h4, 6'h0, 1'b0, FER_IND_K_REAL, 32'h0);
      drop();
      rreg(`FER_A_TAG);
      chk("tags", 80'h0, 80'(v[7:0]));
      stat(16'h0);
      for (int k = 0; k < 3; k++) begin
         op(FER_OP_OTHER, 3'h4, 6'h0, 1'b0, fer_ind_e'(k), 32'h0);
         drop();
         chk1("ind valid", 1'b1, ind_v);
         chk("ind data", indv[k], ind_d);
      end
      stat(st(1, 1, 0, 1));
      go(FER_OP_OTHER, 3'h0, 6'h01);
      stat(st(1, 1, 0, 1));
      wreg(`FER_A_STAT, 32'h0);
      go(FER_OP_OTHER, 3'h0, 6'h01);
      stat(st(1, 0, 0, 0));
      wreg(`FER_A_STAT, 32'h0);
      wreg(`FER_A_TAG, 32'h0000_00FF);
      wreg(`FER_A_CTRL, 32'h0000_003E);
      rreg(`FER_A_STAT);
      t0 = v;
      ip = xs();
      op(FER_OP_OTHER, 3'h2, 6'h0, 1'b0, FER_IND_K_REAL, ip);
      chk1("commit", 1'b0, commit);
      drop();
      chk1("ind valid", 1'b0, ind_v);
      chk1("error pin", 1'b0, err_n);
      stat(st(1, 1, 1, 0));
      chk("top", 80'(t0[13:11]), 80'(v[13:11]));
      rreg(`FER_A_FIP);
      chk("fault ip", 80'(ip), 80'(v));
      rreg(`FER_A_SYS);
      chk1("irq seen", 1'b1, v[2]);
      chk("pic vector", 80'h75, 80'(pvec));
      op(FER_OP_NOWAIT, 3'h0, 6'h0, 1'b0, FER_IND_K_REAL, 32'h0);
      chk1("stall", 1'b0, stall);
      op(FER_OP_FPWAIT, 3'h0, 6'h0, 1'b0, FER_IND_K_REAL, 32'h0);
      chk1("stall", 1'b1, stall);
      wreg(`FER_A_STAT, 32'h0);
      @(negedge clk);
      chk1("stall", 1'b0, stall);
      drop();
      chk1("error pin", 1'b1, err_n);
      op(FER_OP_OTHER, 3'h1, 6'h0, 1'b1, FER_IND_K_REAL, 32'h0);
      drop();
      @(negedge clk);
      chk1("error pin", 1'b1, err_n);
      op(FER_OP_PACKED, 3'h0, 6'h0, 1'b0, FER_IND_K_REAL, 32'h0);
      chk1("stall", 1'b1, stall);
      @(negedge clk);
      chk1("error pin", 1'b0, err_n);
      wreg(`FER_A_STAT, 32'h0);
      drop();
      // ignore is synced by two flops, so let it settle first
      @(posedge clk);
      ign_n <= 1'b0;
      repeat (3) @(posedge clk);
      go(FER_OP_OTHER, 3'h2, 6'h0);
      @(negedge clk);
      chk1("error pin", 1'b1, err_n);
      op(FER_OP_WAIT, 3'h0, 6'h0, 1'b0, FER_IND_K_REAL, 32'h0);
      chk1("stall", 1'b0, stall);
      drop();
      stat(st(1, 1, 1, 0));
      wreg(`FER_A_STAT, 32'h0);
      @(posedge clk);
      ign_n <= 1'b1;
      wreg(`FER_A_SYS, 32'h1);
      go(FER_OP_OTHER, 3'h2, 6'h0);
      op(FER_OP_FPWAIT, 3'h0, 6'h0, 1'b0, FER_IND_K_REAL, 32'h0);
      chk1("stall", 1'b1, stall);
      n = int'(vec16);
      repeat (4) begin
         @(negedge clk);
         n += int'(vec16);
      end
      chk("vector pulses", 80'h1, 80'(n));
      chk1("error pin", 1'b1, err_n);
      wreg(`FER_A_STAT, 32'h0);
      drop();
      wreg(`FER_A_SYS, 32'h0);
      conclude();
   end
endmodule
`default_nettype wire
